/* src/acq_mf_defs.svh */
`ifndef ACQ_MF_DEFS_SVH
`define ACQ_MF_DEFS_SVH

// register indices, byte address is four times the index
`define IDX_CW_STRENGTH_THRESHOLD_WEIGHT_FORCE 8'h4a
`define IDX_SNR_THRESHOLD_ONE                  8'h4c
`define IDX_SNR_THRESHOLD_TWO                  8'h4e
`define IDX_DC_OFFSET_THRESHOLD                8'h50
`define IDX_PREAMBLE_LEAD_COEFF                8'h52
`define IDX_PREAMBLE_LAG_COEFF                 8'h54
`define IDX_PAYLOAD_LEAD_COEFF                 8'h56
`define IDX_PAYLOAD_LAG_COEFF                  8'h58
`define IDX_FALSE_ALARM_TARGET                 8'h5a
`define IDX_ACQUISITION_TIMELINE               8'h5c
`define IDX_ACQUISITION_THRESHOLDS             8'h5e
`define IDX_STEP                               8'h02
`define NUM_REGS                               11

// field positions
`define FORCE_DEFAULT_BIT    6
`define FORCE_CALC_BIT       5
`define CW_THR_MSB           4
`define SNR1_THR_MSB         3
`define SNR2_THR_MSB         4
`define DC_THR_MSB           5
`define COEFF_MSB            5
`define SQ_THR_MSB           5
`define LONG_PRE_DIS_BIT     7
`define DIV_RECEIVED_STRENGTH_LEVEL_BIT         6
`define FAR_DISABLE_BIT      7
`define ED_GATE_BIT          6
`define FAR_TARGET_SHIFT     5

// reset values
`define CFG_RESET            8'h00

// false alarm observation window, in detector samples
`define FAR_WINDOW_SAMPLES   65536

// bus answers
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

/* src/acq_mf_pkg.sv */
package acq_mf_pkg;

  typedef logic [7:0] cfg_byte_t;
  typedef logic [5:0] sq_thr_t;
  typedef logic [1:0] axi_resp_t;

endpackage

/* src/acquisition_mf_control_regs.sv */
// Behaviour
// - force-default bit 6 set makes the receiver always use default weights
// - continuous-wave strength threshold is bits 4:0, 0 to 31 dB
// - first signal-to-noise threshold is bits 3:0, 0 to 15 dB
// - second signal-to-noise threshold is bits 4:0, 0 to 31 dB
// - dc compensation only while strength exceeds noise level plus 6-bit threshold
// - preamble lead and lag coefficients, 6 bits, 000000=0 to 100000=4
// - payload lead and lag coefficients, same 6-bit encoding
// - false alarm disable 0: first quality threshold adapts continuously
// - false alarm disable 1: first quality threshold held at programmed bits 5:0
// - first quality threshold 6 bits, initial detect and adaptation start value
// - acquisition bit 6: 0 quality alone, 1 energy detect and quality
// - timeline bit 7 set treats every preamble as short
// - long preamble diversity uses channel factors or strength per bit 6
// - second quality threshold 6 bits, applied in verify cycle
// - unused bits are plain storage with no effect
// - default weights on the three weak-signal cases, else calculated
`timescale 1ns/100ps
`include "acq_mf_defs.svh"

module acquisition_mf_control_regs
  import acq_mf_pkg::*;
#(
  parameter int FAR_WINDOW = `FAR_WINDOW_SAMPLES
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // axi4-lite write address
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output axi_resp_t        bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output axi_resp_t        rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // receiver status, same clock
  input  wire logic        packet_start,
  input  wire logic        in_payload,
  input  wire logic        continuous_wave,
  input  wire logic        delay_spread_low,
  input  wire logic [7:0]  received_strength_level,
  input  wire logic [7:0]  noise_level_estimate,
  input  wire logic        energy_detect,
  input  wire logic        quality_sample,
  input  wire logic [5:0]  signal_quality_one,
  // receiver controls
  output logic             matched_filter_weights_default,
  output logic             dc_comp_enable,
  output logic [5:0]       loop_lead_coeff,
  output logic [5:0]       loop_lag_coeff,
  output sq_thr_t          sq_threshold_one,
  output sq_thr_t          sq_threshold_two,
  output logic             acquisition_detect,
  output logic             long_preamble_enable,
  output logic             diversity_use_strength
);

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] IDX_FIRST = `IDX_CW_STRENGTH_THRESHOLD_WEIGHT_FORCE;
  localparam int         NREG      = `NUM_REGS;
  localparam int         WCNT_W    = $clog2(FAR_WINDOW + 1);

  cfg_byte_t regs_q [NREG];

  // even indices from the first one, eleven of them, each two words apart
  function automatic logic hit(input logic [31:0] addr);
    logic [7:0] rel;
    rel = addr[9:2] - IDX_FIRST;
    hit = (addr[31:10] == 22'h0) && (addr[9:2] >= IDX_FIRST) && !rel[0]
          && (rel < 8'(`NUM_REGS * 2));
  endfunction

  function automatic logic [3:0] slot(input logic [31:0] addr);
    logic [7:0] rel;
    rel = addr[9:2] - IDX_FIRST;
    slot = rel[4:1];
  endfunction

  // ****************************************************
  // write channel
  // ****************************************************
  logic        aw_full_q;
  logic        w_full_q;
  logic [31:0] awaddr_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  axi_resp_t   bresp_q;

  wire aw_hs     = awvalid & awready_q;
  wire w_hs      = wvalid & wready_q;
  wire do_write  = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_hit    = hit(awaddr_q);
  wire [3:0] wr_slot = slot(awaddr_q);
  wire aw_full_d = aw_full_q ? ~do_write : aw_hs;
  wire w_full_d  = w_full_q ? ~do_write : w_hs;
  wire bvalid_d  = do_write | (bvalid_q & ~bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q  <= ~w_full_d;
      bvalid_q  <= bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 32'h0;
      wdata_q  <= 8'h00;
      wlane_q  <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else begin
      if (aw_hs)
        awaddr_q <= awaddr;
      if (w_hs) begin
        wdata_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (do_write)
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // all eight bits stored, spare ones included, and read back unchanged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= `CFG_RESET;
    end else if (do_write && wr_hit && wlane_q) begin
      regs_q[wr_slot] <= wdata_q;
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  axi_resp_t   rresp_q;

  wire ar_hs    = arvalid & arready_q;
  wire rd_hit   = hit(araddr);
  wire [3:0] rd_slot = slot(araddr);
  wire rvalid_d = ar_hs | (rvalid_q & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_hit ? {24'h0, regs_q[rd_slot]} : 32'h0;
        rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ****************************************************
  // field decode
  // ****************************************************
  wire cfg_byte_t r_cw    = regs_q[0];
  wire cfg_byte_t r_snr1  = regs_q[1];
  wire cfg_byte_t r_snr2  = regs_q[2];
  wire cfg_byte_t r_dc    = regs_q[3];
  wire cfg_byte_t r_plead = regs_q[4];
  wire cfg_byte_t r_plag  = regs_q[5];
  wire cfg_byte_t r_dlead = regs_q[6];
  wire cfg_byte_t r_dlag  = regs_q[7];
  wire cfg_byte_t r_far   = regs_q[8];
  wire cfg_byte_t r_tl    = regs_q[9];
  wire cfg_byte_t r_acq   = regs_q[10];

  wire far_disable = r_acq[`FAR_DISABLE_BIT];
  wire sq_thr_t sq1_prog = r_acq[`SQ_THR_MSB:0];

  // ****************************************************
  // per-packet snapshot
  // ****************************************************
  // a change in mid-packet would upset loops already running, so it waits
  logic       force_def_q;
  logic       force_calc_q;
  logic [4:0] cw_thr_q;
  logic [3:0] snr1_thr_q;
  logic [4:0] snr2_thr_q;
  logic [5:0] dc_thr_q;
  logic [5:0] pre_lead_q;
  logic [5:0] pre_lag_q;
  logic [5:0] pay_lead_q;
  logic [5:0] pay_lag_q;
  logic       ed_gate_q;
  sq_thr_t    sq2_thr_q;
  logic       long_en_q;
  logic       div_received_strength_level_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_def_q  <= 1'b0;
      force_calc_q <= 1'b0;
      cw_thr_q     <= 5'h00;
      snr1_thr_q   <= 4'h0;
      snr2_thr_q   <= 5'h00;
      dc_thr_q     <= 6'h00;
      pre_lead_q   <= 6'h00;
      pre_lag_q    <= 6'h00;
      pay_lead_q   <= 6'h00;
      pay_lag_q    <= 6'h00;
      ed_gate_q    <= 1'b0;
      sq2_thr_q    <= 6'h00;
      long_en_q    <= 1'b0;
      div_received_strength_level_q   <= 1'b0;
    end else if (packet_start) begin
      force_def_q  <= r_cw[`FORCE_DEFAULT_BIT];
      force_calc_q <= r_cw[`FORCE_CALC_BIT];
      cw_thr_q     <= r_cw[`CW_THR_MSB:0];
      snr1_thr_q   <= r_snr1[`SNR1_THR_MSB:0];
      snr2_thr_q   <= r_snr2[`SNR2_THR_MSB:0];
      dc_thr_q     <= r_dc[`DC_THR_MSB:0];
      pre_lead_q   <= r_plead[`COEFF_MSB:0];
      pre_lag_q    <= r_plag[`COEFF_MSB:0];
      pay_lead_q   <= r_dlead[`COEFF_MSB:0];
      pay_lag_q    <= r_dlag[`COEFF_MSB:0];
      ed_gate_q    <= r_acq[`ED_GATE_BIT];
      sq2_thr_q    <= r_tl[`SQ_THR_MSB:0];
      long_en_q    <= ~r_tl[`LONG_PRE_DIS_BIT];
      div_received_strength_level_q   <= r_tl[`DIV_RECEIVED_STRENGTH_LEVEL_BIT];
    end
  end

  // ****************************************************
  // weight selection and dc compensation
  // ****************************************************
  wire [8:0] nf9       = {1'b0, noise_level_estimate};
  wire [8:0] rssi9     = {1'b0, received_strength_level};
  wire [8:0] cw_lim    = nf9 + {4'h0, cw_thr_q};
  wire [8:0] snr1_lim  = nf9 + {5'h00, snr1_thr_q};
  wire [8:0] snr2_lim  = nf9 + {4'h0, snr2_thr_q};
  wire [8:0] dc_lim    = nf9 + {3'h0, dc_thr_q};

  wire weak_signal = (continuous_wave && rssi9 < cw_lim)
                   || (!continuous_wave && rssi9 < snr1_lim)
                   || (!continuous_wave && delay_spread_low && rssi9 < snr2_lim);

  // both forces set is undefined; default is the safer pick
  wire use_default = force_def_q ? 1'b1
                   : force_calc_q ? 1'b0
                   : weak_signal;

  wire dc_en = rssi9 > dc_lim;

  // ****************************************************
  // false alarm adaptation
  // ****************************************************
  logic [WCNT_W-1:0] win_cnt_q;
  logic [16:0]       hits_q;
  sq_thr_t           sq1_thr_q;
  logic              thr_load_q;

  wire quality_hit = signal_quality_one > sq1_thr_q;
  wire win_end     = quality_sample && (win_cnt_q == WCNT_W'(FAR_WINDOW - 1));
  wire [16:0] hits_now = hits_q + {16'h0, quality_hit};
  wire [16:0] target   = {4'h0, r_far, 5'h00};

  // any write of the threshold register with byte lane 0 enabled restarts adaptation from the programmed value,
  // otherwise a value set while adaptation runs would never be used for detection
  wire acq_wr = do_write && wr_hit && wlane_q && (wr_slot == 4'ha);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      thr_load_q <= 1'b0;
    else
      thr_load_q <= acq_wr;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt_q <= '0;
      hits_q    <= 17'h0;
      sq1_thr_q <= 6'h00;
    end else if (far_disable || thr_load_q) begin
      win_cnt_q <= '0;
      hits_q    <= 17'h0;
      sq1_thr_q <= sq1_prog;
    end else if (quality_sample) begin
      win_cnt_q <= win_end ? '0 : win_cnt_q + 1'b1;
      hits_q    <= win_end ? 17'h0 : hits_now;
      // too many hits raise the threshold, too few lower it, one step a window
      if (win_end && hits_now > target && sq1_thr_q != 6'h3f)
        sq1_thr_q <= sq1_thr_q + 6'h01;
      else if (win_end && hits_now < target && sq1_thr_q != 6'h00)
        sq1_thr_q <= sq1_thr_q - 6'h01;
    end
  end

  // ****************************************************
  // output registers
  // ****************************************************
  logic       def_w_q;
  logic       dc_en_q;
  logic [5:0] lead_q;
  logic [5:0] lag_q;
  logic       acq_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      def_w_q <= 1'b0;
      dc_en_q <= 1'b0;
      lead_q  <= 6'h00;
      lag_q   <= 6'h00;
      acq_q   <= 1'b0;
    end else begin
      def_w_q <= use_default;
      dc_en_q <= dc_en;
      lead_q  <= in_payload ? pay_lead_q : pre_lead_q;
      lag_q   <= in_payload ? pay_lag_q : pre_lag_q;
      acq_q   <= quality_sample && quality_hit
                 && (!ed_gate_q || energy_detect);
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  assign matched_filter_weights_default = def_w_q;
  assign dc_comp_enable                 = dc_en_q;
  assign loop_lead_coeff                = lead_q;
  assign loop_lag_coeff                 = lag_q;
  assign sq_threshold_one               = sq1_thr_q;
  assign sq_threshold_two               = sq2_thr_q;
  assign acquisition_detect             = acq_q;
  assign long_preamble_enable           = long_en_q;
  assign diversity_use_strength         = div_received_strength_level_q;

endmodule

/* testbench/acq_mf_regs_sva.sv */
`timescale 1ns/100ps
`include "acq_mf_defs.svh"
// ************
// port checks
// ************
module acq_mf_regs_sva
  import acq_mf_pkg::*;
#(
  parameter int FAR_WINDOW = `FAR_WINDOW_SAMPLES
) (
  // clock, reset and bus handshakes
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire axi_resp_t   bresp,
  input wire logic [31:0] rdata,
  // receiver side
  input wire logic        packet_start,
  input wire logic        in_payload,
  input wire logic        quality_sample,
  input wire logic        acquisition_detect,
  input wire logic        dc_comp_enable,
  input wire logic        long_preamble_enable,
  input wire logic        diversity_use_strength,
  input wire logic [7:0]  received_strength_level,
  input wire logic [7:0]  noise_level_estimate,
  input wire logic [5:0]  signal_quality_one,
  input wire logic [5:0]  loop_lead_coeff,
  input wire sq_thr_t     sq_threshold_one,
  input wire sq_thr_t     sq_threshold_two
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // snapshot outputs may land one or two edges after the packet pulse
  sequence s_pkt;
    $past(packet_start) || $past(packet_start, 2);
  endsequence
  property p_wr_ans;
    awvalid && awready && wvalid && wready && !bvalid |=> !bvalid ##1 bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer timing");
  property p_rd_ans;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer timing");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rhi;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  a_rhi: assert property (p_rhi) else $error("read upper bits set");
  property p_det;
    acquisition_detect |->
      ($past(quality_sample) && $past(signal_quality_one) > $past(sq_threshold_one)) ||
      ($past(quality_sample, 2) && $past(signal_quality_one, 2) > $past(sq_threshold_one, 2));
  endproperty
  a_det: assert property (p_det) else $error("detect without cause");
  property p_dc;
    received_strength_level <= noise_level_estimate |=> !dc_comp_enable;
  endproperty
  a_dc: assert property (p_dc) else $error("dc enable below floor");
  property p_lp;
    $changed(long_preamble_enable) |-> s_pkt;
  endproperty
  a_lp: assert property (p_lp) else $error("timeline mode moved");
  property p_div;
    $changed(diversity_use_strength) |-> s_pkt;
  endproperty
  a_div: assert property (p_div) else $error("diversity mode moved");
  property p_sq2;
    $changed(sq_threshold_two) |-> s_pkt;
  endproperty
  a_sq2: assert property (p_sq2) else $error("verify threshold moved");
  property p_coef;
    $changed(loop_lead_coeff) |-> s_pkt or $past(in_payload) != $past(in_payload, 2);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient moved");
  c_det: cover property (acquisition_detect);
  c_err: cover property (bvalid && bresp == `RESP_SLVERR);
  c_pkt: cover property (packet_start);
endmodule

bind acquisition_mf_control_regs acq_mf_regs_sva #(.FAR_WINDOW(FAR_WINDOW)) u_sva (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
  .arready, .rvalid, .rready, .bresp, .rdata, .packet_start, .in_payload, .quality_sample,
  .acquisition_detect, .dc_comp_enable, .long_preamble_enable, .diversity_use_strength,
  .received_strength_level, .noise_level_estimate, .signal_quality_one, .loop_lead_coeff,
  .sq_threshold_one, .sq_threshold_two);

/* testbench/testbench.sv */
`timescale 1ns/100ps
`include "acq_mf_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
// ***********
// bench
// ***********
module testbench
  import acq_mf_pkg::*;
();
  localparam int FW = 64; // short window keeps the adaptation run brief
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 0;
  logic packet_start = 0, in_payload = 0, continuous_wave = 0, delay_spread_low = 0;
  logic energy_detect = 0, quality_sample = 0;
  logic [7:0] received_strength_level = 0, noise_level_estimate = 0;
  logic [5:0] signal_quality_one = 0, loop_lead_coeff, loop_lag_coeff;
  logic awready, wready, bvalid, arready, rvalid, matched_filter_weights_default;
  logic dc_comp_enable, acquisition_detect, long_preamble_enable, diversity_use_strength;
  axi_resp_t bresp, rresp;
  sq_thr_t sq_threshold_one, sq_threshold_two;
  int n_errors = 0, n_tests = 0;
  int mdl[11];

  acquisition_mf_control_regs #(.FAR_WINDOW(FW)) u_acquisition_mf_control_regs (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .packet_start, .in_payload, .continuous_wave,
    .delay_spread_low, .received_strength_level, .noise_level_estimate, .energy_detect,
    .quality_sample, .signal_quality_one, .matched_filter_weights_default, .dc_comp_enable,
    .loop_lead_coeff, .loop_lag_coeff, .sq_threshold_one, .sq_threshold_two,
    .acquisition_detect, .long_preamble_enable, .diversity_use_strength);

  initial begin
    forever #25 aclk = ~aclk;
  end

  function automatic logic [31:0] ad(input int i);
    return 32'((`IDX_CW_STRENGTH_THRESHOLD_WEIGHT_FORCE + `IDX_STEP * i) * 4);
  endfunction

  // ready is raised only after the answer shows, so the hold path gets exercised
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic s,
                    input axi_resp_t e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'($urandom), d};
    wstrb <= {3'($urandom), s};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid && !bready) bready <= 1;
    end while (!(bvalid && bready));
    bready <= 0;
    `CHK(bresp, e)
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input axi_resp_t er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid && !rready) rready <= 1;
    end while (!(rvalid && rready));
    rready <= 0;
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask

  task automatic false_alarm_rate(input logic [5:0] v, input logic [5:0] e);
    repeat (FW) begin
      @(posedge aclk);
      signal_quality_one <= v;
      quality_sample <= 1;
      @(posedge aclk);
      quality_sample <= 0;
    end
    repeat (3) @(posedge aclk);
    `CHK(sq_threshold_one, e)
  endtask

  task automatic complete_run();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end

  initial begin
    int v, f, r, nf, dflt;
    logic [2:0] seen;
    logic s;
    void'($urandom(32'h38c2));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 11; i++) rd(ad(i), 32'h0, `RESP_OKAY);
    `CHK(long_preamble_enable, 1'b0)
    wr(32'h0, 8'h5a, 1, `RESP_SLVERR);
    rd(32'h4, 32'h0, `RESP_SLVERR);
    for (int n = 0; n < 30; n++) begin
      for (int i = 0; i < 11; i++) begin
        v = $urandom_range(255);
        if (i == 0 && v[6:5] == 2'b11) v[5] = 0;
        if (i == 10) v[7] = 1;
        s = (n == 0) || 1'($urandom);
        wr(ad(i), 8'(v), s, `RESP_OKAY);
        if (s) mdl[i] = v;
      end
      for (int i = 0; i < 11; i++) rd(ad(i), 32'(mdl[i]), `RESP_OKAY);
      @(posedge aclk);
      {continuous_wave, delay_spread_low, in_payload, energy_detect} <= 4'($urandom);
      received_strength_level <= 8'($urandom_range(110));
      noise_level_estimate <= 8'($urandom_range(40));
      packet_start <= 1;
      @(posedge aclk);
      packet_start <= 0;
      repeat (3) @(posedge aclk);
      #1;
      f = mdl[0];
      r = received_strength_level;
      nf = noise_level_estimate;
      dflt = f[6] ? 1 : f[5] ? 0 : (continuous_wave && r < f[4:0] + nf) ||
             (!continuous_wave && r < mdl[1][3:0] + nf) ||
             (!continuous_wave && delay_spread_low && r < mdl[2][4:0] + nf);
      `CHK(matched_filter_weights_default, 1'(dflt))
      `CHK(dc_comp_enable, 1'(r > mdl[3][5:0] + nf))
      `CHK(loop_lead_coeff, 6'(mdl[in_payload ? 6 : 4]))
      `CHK(loop_lag_coeff, 6'(mdl[in_payload ? 7 : 5]))
      `CHK(sq_threshold_two, 6'(mdl[9]))
      `CHK(long_preamble_enable, 1'(!mdl[9][7]))
      `CHK(diversity_use_strength, 1'(mdl[9][6]))
      `CHK(sq_threshold_one, 6'(mdl[10]))
      @(posedge aclk);
      signal_quality_one <= 6'($urandom);
      quality_sample <= 1;
      @(posedge aclk);
      quality_sample <= 0;
      seen = 3'h0;
      repeat (3) begin
        #1;
        seen = {seen[1:0], acquisition_detect};
        @(posedge aclk);
      end
      v = (signal_quality_one > mdl[10][5:0]) && (!mdl[10][6] || energy_detect);
      `CHK(seen, 3'(v << 2))
    end
    wr(ad(8), 8'h01, 1, `RESP_OKAY);
    wr(ad(10), 8'h85, 1, `RESP_OKAY);
    wr(ad(10), 8'h09, 1, `RESP_OKAY);
    `CHK(sq_threshold_one, 6'h09)
    wr(ad(10), 8'h05, 1, `RESP_OKAY);
    false_alarm_rate(6'h3f, 6'h06);
    false_alarm_rate(6'h00, 6'h05);
    complete_run();
  end
endmodule
